// ---- design/clk_gate_pkg.sv ----
// Constants and types shared by the run-mode unit clock gate design.
// Assumes a 32-bit APB with full 32-bit byte addresses.
package clk_gate_pkg;

  localparam logic [31:0] SYSCTL_BASE = 32'h400F_E000;
  localparam logic [31:0] RUN_GATE_OFS = 32'h0000_0104;
  localparam logic [31:0] IRQ_STATUS_OFS = 32'h0000_0200;
  localparam logic [31:0] IRQ_MASK_OFS = 32'h0000_0204;
  localparam logic [31:0] EFF_GATE_OFS = 32'h0000_0208;

  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  // Timers 19:16, two-wire 14/12, decoders 9:8, sync 5:4, async 2:0
  localparam logic [31:0] GATE_WR_MASK = 32'h000F_5337;
  localparam logic [31:0] UPPER_MASK = 32'hFFF0_0000;

  localparam int UNIT_IDX_W = 5;
  localparam int IRQ_W = 2;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_GATE_CHG_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP_SLEEP
  } power_mode_t;

  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [31:0] ofs);
    reg_hit = (addr == SYSCTL_BASE + ofs);
  endfunction

endpackage

// ---- design/gate_if.sv ----
// Carries unit enables and unit access checks between the controller
// and the access guard. Assumes one clock domain.
`timescale 1ns/1ps
interface gate_if;
  logic [31:0] en;
  logic req;
  logic [clk_gate_pkg::UNIT_IDX_W-1:0] idx;
  logic resp_valid;
  logic fault;
  modport ctrl (output en, output req, output idx,
                input resp_valid, input fault);
  modport guard (input en, input req, input idx,
                 output resp_valid, output fault);
endinterface

// ---- design/gate_mode_mux.sv ----
// Picks the gating vector that applies in the current power mode.
// Assumes the mode and companion vectors come from the power controller.
`timescale 1ns/1ps
module gate_mode_mux (
  input wire logic [31:0] run_gate,
  input wire logic [31:0] sleep_gate,
  input wire logic [31:0] deep_gate,
  input wire clk_gate_pkg::power_mode_t mode,
  input wire logic auto_gating_select,
  output logic [31:0] eff_gate
);
  import clk_gate_pkg::*;

  // Without auto gating the run vector stays in force in every mode
  always_comb begin
    eff_gate = run_gate;
    if (auto_gating_select) begin
      unique case (mode)
        MODE_RUN: eff_gate = run_gate;
        MODE_SLEEP: eff_gate = sleep_gate & GATE_WR_MASK;
        MODE_DEEP_SLEEP: eff_gate = deep_gate & GATE_WR_MASK;
        default: eff_gate = run_gate;
      endcase
    end
  end
endmodule

// ---- design/unit_access_guard.sv ----
// Answers each unit access one cycle later, faulting gated units.
// Assumes the controller holds req for one cycle per access.
`timescale 1ns/1ps
module unit_access_guard (
  input wire logic pclk,
  input wire logic presetn,
  gate_if.guard g
);
  import clk_gate_pkg::*;

  typedef struct packed {
    logic resp_valid;
    logic fault;
  } guard_st_t;

  guard_st_t st_r;
  guard_st_t st_nxt;

  always_comb begin
    st_nxt.resp_valid = g.req;
    st_nxt.fault = g.req && !g.en[g.idx];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign g.resp_valid = st_r.resp_valid;
  assign g.fault = st_r.fault;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fault_gated_unit: assert property (
    g.req && !g.en[g.idx] |=> g.resp_valid && g.fault)
    else $error("gated unit access not faulted");
  a_grant_enabled_unit: assert property (
    g.req && g.en[g.idx] |=> g.resp_valid && !g.fault)
    else $error("enabled unit access faulted");
  c_fault_seen: cover property (g.resp_valid && g.fault);
endmodule

// ---- design/run_clock_gate_ctrl.sv ----
// Run-mode unit clock gate register with APB slave, fault guard, irq.
// Assumes a zero-wait APB master and synchronous mode inputs.
// Notes on behaviour
// - each writable bit enables one unit clock
// - access to gated unit returns bus fault
// - reset clears every gating bit
// - run register rules; sleep vectors need auto
// - bits 19..16 gate timers three..zero
// - bit 14 two-wire one, bit 12 zero
// - bits 9, 8 gate quadrature decoders
// - bits 5, 4 gate synchronous serial ports
// - bits 2..0 gate asynchronous serial ports
// - reserved low bits read zero, unwritable
// - register sits at base plus 0x104
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module run_clock_gate_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire clk_gate_pkg::power_mode_t power_mode,
  input wire logic auto_gating_select,
  input wire logic [31:0] sleep_gate_value,
  input wire logic [31:0] deep_sleep_gate_value,
  input wire logic unit_req,
  input wire logic [clk_gate_pkg::UNIT_IDX_W-1:0] unit_idx,
  output logic unit_resp_valid,
  output logic unit_fault,
  output logic [31:0] unit_clk_en,
  output logic irq
);
  import clk_gate_pkg::*;

  typedef struct packed {
    logic [31:0] run_gate;
    logic [31:0] unit_en;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
    logic slverr;
  } ctrl_st_t;

  ctrl_st_t st_r;
  ctrl_st_t st_nxt;
  logic [31:0] eff_gate;
  logic setup;
  logic access;
  logic hit_run;
  logic hit_stat;
  logic hit_mask;
  logic hit_eff;
  logic hit_any;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr;

  gate_if g ();

  gate_mode_mux u_mux (
    .run_gate(st_r.run_gate),
    .sleep_gate(sleep_gate_value),
    .deep_gate(deep_sleep_gate_value),
    .mode(power_mode),
    .auto_gating_select(auto_gating_select),
    .eff_gate(eff_gate)
  );

  unit_access_guard u_guard (
    .pclk(pclk),
    .presetn(presetn),
    .g(g.guard)
  );

  assign g.en = st_r.unit_en;
  assign g.req = unit_req;
  assign g.idx = unit_idx;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_run = reg_hit(paddr, RUN_GATE_OFS);
  assign hit_stat = reg_hit(paddr, IRQ_STATUS_OFS);
  assign hit_mask = reg_hit(paddr, IRQ_MASK_OFS);
  assign hit_eff = reg_hit(paddr, EFF_GATE_OFS);
  assign hit_any = hit_run || hit_stat || hit_mask || hit_eff;

  always_comb begin
    st_nxt = st_r;
    events = '0;
    clr = '0;
    // Applies the effective vector a cycle late so outputs come from flops
    st_nxt.unit_en = eff_gate;
    events[IRQ_FAULT_BIT] = g.resp_valid && g.fault;
    events[IRQ_GATE_CHG_BIT] = (eff_gate != st_r.unit_en);
    // Read data is latched in setup so the zero-wait access can return it
    if (setup) begin
      st_nxt.slverr = !hit_any;
      st_nxt.rdata = '0;
      if (!pwrite) begin
        if (hit_run) begin
          st_nxt.rdata = st_r.run_gate;
        end
        if (hit_stat) begin
          st_nxt.rdata[IRQ_W-1:0] = st_r.irq_status;
        end
        if (hit_mask) begin
          st_nxt.rdata[IRQ_W-1:0] = st_r.irq_mask;
        end
        if (hit_eff) begin
          st_nxt.rdata = st_r.unit_en;
        end
      end
    end
    if (access && pwrite && hit_run) begin
      // Reserved and upper bits never store a one
      st_nxt.run_gate = pwdata & GATE_WR_MASK;
      // Same mask covers the remaining unit groups
      // Reserved low and upper positions stay zero
      // Upper positions drop writes as well
    end
    if (access && pwrite && hit_mask) begin
      st_nxt.irq_mask = pwdata[IRQ_W-1:0];
    end
    if (access && !pwrite && hit_stat) begin
      clr = st_r.irq_status;
    end
    // An event in the clearing cycle survives the read
    st_nxt.irq_status = (st_r.irq_status & ~clr) | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.run_gate <= GATE_RESET;
      st_r.unit_en <= GATE_RESET;
      st_r.irq_status <= IRQ_RESET;
      st_r.irq_mask <= IRQ_RESET;
      st_r.rdata <= '0;
      st_r.slverr <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = st_r.slverr && access;
  assign unit_resp_valid = g.resp_valid;
  assign unit_fault = g.fault;
  assign unit_clk_en = st_r.unit_en;
  assign irq = |(st_r.irq_status & st_r.irq_mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_gate_reset_zero: assert property (
    !$past(presetn) |-> st_r.run_gate == GATE_RESET &&
      unit_clk_en == GATE_RESET)
    else $error("gate not cleared by reset");
  a_reserved_low_zero: assert property (
    (st_r.run_gate & ~GATE_WR_MASK & ~UPPER_MASK) == '0)
    else $error("reserved gate bit set");
  a_upper_bits_zero: assert property (
    access && !pwrite && hit_run |-> (prdata & UPPER_MASK) == '0)
    else $error("upper gate bits read nonzero");
  a_write_gate_value: assert property (
    access && pwrite && hit_run |=>
      st_r.run_gate == ($past(pwdata) & GATE_WR_MASK))
    else $error("gate write not stored as masked value");
  a_write_readback: assert property (
    access && pwrite && hit_run ##1 setup && !pwrite && hit_run ##1
      access |-> prdata == st_r.run_gate)
    else $error("gate readback mismatch");
  a_run_mode_enable: assert property (
    power_mode == MODE_RUN || !auto_gating_select |=>
      unit_clk_en == $past(st_r.run_gate))
    else $error("run vector not applied to unit enables");
  a_unmapped_error: assert property (
    setup && !hit_any |=> penable |-> pslverr)
    else $error("unmapped address not refused");
  a_fault_sets_irq: assert property (
    unit_resp_valid && unit_fault |=> st_r.irq_status[IRQ_FAULT_BIT])
    else $error("bus fault did not set status");

  // Each unit group stores exactly the bits written to it
  a_timer_bits_store: assert property (
    access && pwrite && hit_run |=>
      st_r.run_gate[19:16] == $past(pwdata[19:16]))
    else $error("timer gate bits not stored");
  a_two_wire_store: assert property (
    access && pwrite && hit_run |=>
      {st_r.run_gate[14], st_r.run_gate[12]} ==
      {$past(pwdata[14]), $past(pwdata[12])})
    else $error("two-wire gate bits not stored");
  a_decoder_store: assert property (
    access && pwrite && hit_run |=>
      st_r.run_gate[9:8] == $past(pwdata[9:8]))
    else $error("decoder gate bits not stored");
  a_sync_serial_store: assert property (
    access && pwrite && hit_run |=>
      st_r.run_gate[5:4] == $past(pwdata[5:4]))
    else $error("sync serial gate bits not stored");
  a_async_serial_store: assert property (
    access && pwrite && hit_run |=>
      st_r.run_gate[2:0] == $past(pwdata[2:0]))
    else $error("async serial gate bits not stored");
  a_gate_hold: assert property (
    !(access && pwrite && hit_run) |=> $stable(st_r.run_gate))
    else $error("gate changed without a write");

  // In run operation each group reaches its unit enables a cycle later
  a_timer_enable_out: assert property (
    !auto_gating_select || power_mode == MODE_RUN |=>
      unit_clk_en[19:16] == $past(st_r.run_gate[19:16]))
    else $error("timer enables not driven");
  a_two_wire_enable_out: assert property (
    !auto_gating_select || power_mode == MODE_RUN |=>
      {unit_clk_en[14], unit_clk_en[12]} ==
      {$past(st_r.run_gate[14]), $past(st_r.run_gate[12])})
    else $error("two-wire enables not driven");
  a_decoder_enable_out: assert property (
    !auto_gating_select || power_mode == MODE_RUN |=>
      unit_clk_en[9:8] == $past(st_r.run_gate[9:8]))
    else $error("decoder enables not driven");
  a_sync_enable_out: assert property (
    !auto_gating_select || power_mode == MODE_RUN |=>
      unit_clk_en[5:4] == $past(st_r.run_gate[5:4]))
    else $error("sync serial enables not driven");
  a_async_enable_out: assert property (
    !auto_gating_select || power_mode == MODE_RUN |=>
      unit_clk_en[2:0] == $past(st_r.run_gate[2:0]))
    else $error("async serial enables not driven");

  // Companion vectors only take over with auto gating selected
  a_sleep_vector_used: assert property (
    auto_gating_select && power_mode == MODE_SLEEP |=>
      unit_clk_en == ($past(sleep_gate_value) & GATE_WR_MASK))
    else $error("sleep vector not applied");
  a_deep_vector_used: assert property (
    auto_gating_select && power_mode == MODE_DEEP_SLEEP |=>
      unit_clk_en == ($past(deep_sleep_gate_value) & GATE_WR_MASK))
    else $error("deep sleep vector not applied");

  // Reads of the gate never expose a reserved or upper one
  a_reserved_read_zero: assert property (
    access && !pwrite && hit_run |-> (prdata & ~GATE_WR_MASK) == '0)
    else $error("reserved gate bit read nonzero");
  a_eff_readback: assert property (
    access && !pwrite && hit_eff && $past(setup) |->
      prdata == $past(st_r.unit_en))
    else $error("effective enables read wrong");

  // Refused addresses leave state alone and read zero
  a_unmapped_no_write: assert property (
    access && pwrite && !hit_any |=> $stable(st_r.run_gate))
    else $error("unmapped write changed gate");
  a_unmapped_read_zero: assert property (
    access && !pwrite && !hit_any && $past(setup) |-> prdata == '0)
    else $error("unmapped read returned data");
  a_mapped_no_error: assert property (
    access && hit_any |-> !pslverr)
    else $error("mapped access refused");

  // Status bits are sticky until read; an event in the read cycle wins
  a_fault_sticky: assert property (
    st_r.irq_status[IRQ_FAULT_BIT] && !(access && !pwrite && hit_stat)
      |=> st_r.irq_status[IRQ_FAULT_BIT])
    else $error("fault status lost before read");
  a_status_read_clear: assert property (
    access && !pwrite && hit_stat && events == '0 |=>
      st_r.irq_status == '0)
    else $error("status not cleared by read");
  a_change_event: assert property (
    unit_clk_en != $past(unit_clk_en) |->
      st_r.irq_status[IRQ_GATE_CHG_BIT])
    else $error("enable change not flagged");
  a_mask_write: assert property (
    access && pwrite && hit_mask |=>
      st_r.irq_mask == $past(pwdata[IRQ_W-1:0]))
    else $error("mask write not stored");
  a_reset_quiet: assert property (
    !$past(presetn) |-> !irq && !unit_resp_valid && !pslverr)
    else $error("outputs active right after reset");

  c_unmapped_access: cover property (access && !hit_any);

  c_gate_write: cover property (access && pwrite && hit_run);
  c_sleep_vector: cover property (auto_gating_select &&
    power_mode == MODE_SLEEP);
  c_irq_raised: cover property (irq);
endmodule

// ---- test/unit_bank_model.sv ----
// Model of the gated unit bank: issues unit accesses and keeps answers.
// Assumes it shares pclk and presetn with the gate controller.
`timescale 1ns/1ps
module unit_bank_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [clk_gate_pkg::UNIT_IDX_W-1:0] tgt,
  input wire logic unit_resp_valid,
  input wire logic unit_fault,
  output logic unit_req,
  output logic [clk_gate_pkg::UNIT_IDX_W-1:0] unit_idx,
  output logic fault_seen
);
  // Index keeps rolling while idle and wraps after 31; each go reloads it from tgt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_req <= '0;
      unit_idx <= '0;
      fault_seen <= '0;
    end else begin
      unit_req <= go;
      unit_idx <= go ? tgt : unit_idx + 1'h1;
      if (unit_resp_valid) begin
        fault_seen <= unit_fault;
      end
    end
  end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the run-mode unit clock gate register.
// Assumes a 100 MHz pclk and an APB slave with immediate pready.
`timescale 1ns/1ps
module tb_top;
  import clk_gate_pkg::*;
  localparam logic [31:0] GATE = SYSCTL_BASE + RUN_GATE_OFS;
  localparam logic [31:0] STAT = SYSCTL_BASE + IRQ_STATUS_OFS;
  localparam logic [31:0] WR = 32'h000F_5337;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [31:0] paddr = '0, pwdata = '0, sv = '0, dv = '0, prdata, clk_en;
  logic [31:0] rd;
  logic pready, pslverr, ureq, uvalid, ufault, irq, fseen, err;
  logic auto = '0, go = '0;
  logic [UNIT_IDX_W-1:0] uidx, tgt = '0;
  power_mode_t pm = MODE_RUN;
  int fails = 0, comparisons = 0, cyc = 0;

  run_clock_gate_ctrl i_run_clock_gate_ctrl (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_mode(pm), .auto_gating_select(auto),
    .sleep_gate_value(sv), .deep_sleep_gate_value(dv), .unit_req(ureq),
    .unit_idx(uidx), .unit_resp_valid(uvalid), .unit_fault(ufault),
    .unit_clk_en(clk_en), .irq(irq));
  unit_bank_model i_unit_bank_model (.pclk(pclk), .presetn(presetn),
    .go(go), .tgt(tgt), .unit_resp_valid(uvalid), .unit_fault(ufault),
    .unit_req(ureq), .unit_idx(uidx), .fault_seen(fseen));

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Settle: let n edges and their updates land
  task automatic hop(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic acc(input int i);
    @(posedge pclk);
    go <= 1'h1;
    tgt <= i[UNIT_IDX_W-1:0];
    @(posedge pclk);
    go <= 1'h0;
    hop(2);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(0, GATE, '0);
    chk(rd, 32'h0000_0000);
    chk(clk_en, 32'h0000_0000);
    apb(1, GATE, 32'hFFFF_FFFF);
    apb(0, GATE, '0);
    chk(rd, WR);
    hop(2);
    chk(clk_en, WR);
    for (int i = 0; i < 32; i++) begin
      acc(i);
      chk(fseen, {31'h0000_0000, ~WR[i]});
    end
    apb(0, STAT, '0);
    apb(1, SYSCTL_BASE + IRQ_MASK_OFS, 32'h0000_0001);
    apb(0, SYSCTL_BASE + IRQ_MASK_OFS, '0);
    chk(rd, 32'h0000_0001);
    apb(1, GATE, 32'h0000_0001);
    hop(2);
    chk(irq, 32'h0000_0000);
    acc(8);
    chk(fseen, 32'h0000_0001);
    hop(1);
    chk(irq, 32'h0000_0001);
    apb(0, STAT, '0);
    chk(rd, 32'h0000_0003);
    apb(0, STAT, '0);
    chk(rd, 32'h0000_0000);
    hop(1);
    chk(irq, 32'h0000_0000);
    apb(1, SYSCTL_BASE + 32'h0000_0100, 32'hFFFF_FFFF);
    chk(err, 32'h0000_0001);
    apb(0, GATE, '0);
    chk(rd, 32'h0000_0001);
    chk(err, 32'h0000_0000);
    @(posedge pclk);
    pm <= MODE_SLEEP;
    sv <= 32'hFFFF_FFFF;
    dv <= 32'h0000_0010;
    hop(2);
    chk(clk_en, 32'h0000_0001);
    @(posedge pclk);
    auto <= 1'h1;
    hop(2);
    chk(clk_en, WR);
    @(posedge pclk);
    pm <= MODE_DEEP_SLEEP;
    hop(2);
    chk(clk_en, 32'h0000_0010);
    apb(0, SYSCTL_BASE + EFF_GATE_OFS, '0);
    chk(rd, 32'h0000_0010);
    @(posedge pclk);
    pm <= MODE_RUN;
    presetn <= 1'h0;
    hop(2);
    @(posedge pclk);
    presetn <= 1'h1;
    apb(0, GATE, '0);
    chk(rd, 32'h0000_0000);
    wrap_up();
  end
endmodule
